//--- common/serial_port_map.vh
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH
// Register offsets
`define REG_CONTROL 3'h0
`define REG_STATUS 3'h1
`define REG_TX_DATA 3'h2
`define REG_RX_DATA 3'h3
// Control bit positions
`define CTL_PORT_ENABLE 0
`define CTL_RECEIVE_ENABLE 1
`define CTL_TRANSMITTER_ENABLE 2
`define CTL_NINE_BIT_TX 3
`define CTL_NINE_BIT_RX 4
`define CTL_CLOCKED_MODE 5
`define CTL_POLARITY_INVERT 6
`define CTL_TX_NINTH_BIT 7
`define CONTROL_RESET 8'h00
// Status bit positions
`define STA_TX_FLAG 0
`define STA_RX_FLAG 1
`define STA_FRAMING_ERROR 2
`define STA_OVERRUN_ERROR 3
`define STA_RX_NINTH_BIT 4
`define STA_SHIFTER_EMPTY 5
// Oversampling counts and receive buffer depth
`define TICKS_PER_BIT 4'hF
`define TICKS_HALF_BIT 4'h7
`define RX_FIFO_DEPTH 2
`endif

//--- rtl/serial_rx_fifo.v
`timescale 1ns/1ps
`default_nettype none
module serial_rx_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 2
) (
	input wire clk_in,
	input wire rstn_in,
	input wire flush_in,
	input wire push_valid_in,
	output wire push_ready_out,
	input wire [WIDTH-1:0] push_data_in,
	output wire pop_valid_out,
	input wire pop_ready_in,
	output wire [WIDTH-1:0] pop_data_out
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [31:0] count_r;
	wire do_push;
	wire do_pop;
	genvar gi;

	assign push_ready_out = (count_r < DEPTH);
	assign pop_valid_out = (count_r != 0);
	assign do_push = push_valid_in & push_ready_out;
	assign do_pop = pop_ready_in & pop_valid_out;
	assign pop_data_out = mem_r[0];

	// Entry 0 is always the oldest; entries slide down on a pop
	generate
		for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_entry
			always @(posedge clk_in) begin
				if (!rstn_in) begin
					mem_r[gi] <= {WIDTH{1'b0}};
				end else if (do_pop && do_push && count_r == gi + 1) begin
					mem_r[gi] <= push_data_in;
				end else if (do_pop) begin
					if (gi < DEPTH - 1)
						mem_r[gi] <= mem_r[(gi < DEPTH - 1) ? gi + 1 : gi];
				end else if (do_push && count_r == gi) begin
					mem_r[gi] <= push_data_in;
				end
			end
		end
	endgenerate

	always @(posedge clk_in) begin
		if (!rstn_in || flush_in) begin
			count_r <= 32'h0;
		end else if (do_push && !do_pop) begin
			count_r <= count_r + 32'h1;
		end else if (do_pop && !do_push) begin
			count_r <= count_r - 32'h1;
		end
	end
endmodule
`default_nettype wire

//--- rtl/serial_tx.v
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.vh"
module serial_tx (
	input wire clk_in,
	input wire rstn_in,
	input wire run_in,
	input wire tick_in,
	input wire nine_bit_in,
	input wire invert_in,
	input wire load_in,
	input wire [8:0] load_data_in,
	output wire hold_full_out,
	output wire shifter_empty_out,
	output reg line_out
);
	reg [8:0] hold_r;
	reg hold_full_r;
	reg [10:0] shifter_r;
	reg [3:0] bits_left_r;
	reg [3:0] tick_cnt_r;
	reg busy_r;

	assign hold_full_out = hold_full_r;
	assign shifter_empty_out = ~busy_r;

	always @(posedge clk_in) begin
		if (!rstn_in || !run_in) begin
			hold_r <= 9'h000;
			hold_full_r <= 1'b0;
			shifter_r <= 11'h7FF;
			bits_left_r <= 4'h0;
			tick_cnt_r <= 4'h0;
			busy_r <= 1'b0;
			line_out <= 1'b1;
		end else begin
			if (load_in) begin
				hold_r <= load_data_in;
				hold_full_r <= 1'b1;
			end
			if (!busy_r && hold_full_r && !load_in) begin
				// Stop, optional ninth, eight data, start; LSB first
				shifter_r <= nine_bit_in ? {1'b1, hold_r, 1'b0} :
					{2'b11, hold_r[7:0], 1'b0};
				bits_left_r <= nine_bit_in ? 4'hB : 4'hA;
				hold_full_r <= 1'b0;
				tick_cnt_r <= 4'h0;
				busy_r <= 1'b1;
			end else if (busy_r && tick_in) begin
				if (tick_cnt_r == `TICKS_PER_BIT) begin
					tick_cnt_r <= 4'h0;
					shifter_r <= {1'b1, shifter_r[10:1]};
					bits_left_r <= bits_left_r - 4'h1;
					if (bits_left_r == 4'h1)
						busy_r <= 1'b0;
				end else begin
					tick_cnt_r <= tick_cnt_r + 4'h1;
				end
			end
			line_out <= (busy_r ? shifter_r[0] : 1'b1) ^ invert_in;
		end
	end
endmodule
`default_nettype wire

//--- rtl/serial_port.v
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.vh"
module serial_port (
	input wire clk_in,
	input wire rstn_in,
	input wire baud_tick_in,
	input wire [2:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [7:0] rdata_out,
	input wire receive_line_in,
	output wire transmit_line_out,
	output wire receive_interrupt_flag_out,
	output wire transmit_interrupt_flag_out
);
	localparam ST_IDLE = 2'h0;
	localparam ST_START = 2'h1;
	localparam ST_DATA = 2'h2;
	localparam ST_STOP = 2'h3;

	reg [7:0] control_r;
	reg [1:0] rx_state_r;
	reg [1:0] rx_state_nxt;
	reg [3:0] rx_tick_cnt_r;
	reg [3:0] rx_bits_r;
	reg [8:0] receive_shifter_r;
	reg [2:0] sample_hist_r;
	reg line_prev_r;
	reg line_meta_r;
	reg line_sync_r;
	reg overrun_error_r;
	reg push_r;
	reg [9:0] push_data_r;
	reg rx_nine_r;

	wire port_enable;
	wire receive_enable;
	wire transmitter_enable;
	wire nine_bit_transmit_select;
	wire nine_bit_receive_select;
	wire clocked_mode_select;
	wire polarity_invert;
	wire transmit_ninth_bit;
	wire rx_active;
	wire majority;
	wire centre_tick;
	wire fifo_ready;
	wire fifo_valid;
	wire [9:0] fifo_head;
	wire fifo_pop;
	wire fifo_flush;
	wire tx_hold_full;
	wire tx_shifter_empty;
	wire tx_load;
	wire [7:0] status_word;
	wire start_edge;
	wire data_sample;
	wire stop_sample;
	wire head_framing_error;
	wire head_ninth_bit;

	assign port_enable = control_r[`CTL_PORT_ENABLE];
	assign receive_enable = control_r[`CTL_RECEIVE_ENABLE];
	assign transmitter_enable = control_r[`CTL_TRANSMITTER_ENABLE];
	assign nine_bit_transmit_select = control_r[`CTL_NINE_BIT_TX];
	assign nine_bit_receive_select = control_r[`CTL_NINE_BIT_RX];
	assign clocked_mode_select = control_r[`CTL_CLOCKED_MODE];
	assign polarity_invert = control_r[`CTL_POLARITY_INVERT];
	assign transmit_ninth_bit = control_r[`CTL_TX_NINTH_BIT];

	// Control register; the ninth transmit bit lives here so it is
	// latched before the data byte write that consumes it
	always @(posedge clk_in) begin
		if (!rstn_in) begin
			control_r <= `CONTROL_RESET;
		end else if (wr_in && addr_in == `REG_CONTROL) begin
			control_r <= wdata_in;
		end
	end

	// Transmit side

	assign tx_load = wr_in && addr_in == `REG_TX_DATA &&
		port_enable && transmitter_enable && !clocked_mode_select;

	serial_tx u_tx (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.run_in(port_enable & transmitter_enable),
		.tick_in(baud_tick_in),
		.nine_bit_in(nine_bit_transmit_select),
		.invert_in(polarity_invert),
		.load_in(tx_load),
		.load_data_in({transmit_ninth_bit, wdata_in}),
		.hold_full_out(tx_hold_full),
		.shifter_empty_out(tx_shifter_empty),
		.line_out(transmit_line_out)
	);

	// Flag rises as soon as the enable is set since the holder is empty
	assign transmit_interrupt_flag_out = port_enable &&
		transmitter_enable && !tx_hold_full;

	// Receive side

	// Two-stage synchroniser; only the second stage feeds logic
	always @(posedge clk_in) begin
		if (!rstn_in) begin
			line_meta_r <= 1'b1;
			line_sync_r <= 1'b1;
		end else begin
			line_meta_r <= receive_line_in;
			line_sync_r <= line_meta_r;
		end
	end

	assign rx_active = port_enable && receive_enable &&
		!clocked_mode_select;

	// Three most recent oversamples around the bit centre
	assign majority = (sample_hist_r[0] & sample_hist_r[1]) |
		(sample_hist_r[1] & sample_hist_r[2]) |
		(sample_hist_r[0] & sample_hist_r[2]);

	assign centre_tick = baud_tick_in && ((rx_state_r == ST_START) ?
		(rx_tick_cnt_r == `TICKS_HALF_BIT) :
		(rx_tick_cnt_r == `TICKS_PER_BIT));

	// Judged tick to tick, so a long low run is one edge only
	assign start_edge = baud_tick_in && line_prev_r &&
		!line_sync_r;
	assign data_sample = rx_state_r == ST_DATA && centre_tick;
	assign stop_sample = rx_state_r == ST_STOP && centre_tick;

	always @(posedge clk_in) begin
		if (!rstn_in || !rx_active) begin
			sample_hist_r <= 3'h7;
			line_prev_r <= 1'b1;
		end else if (baud_tick_in) begin
			sample_hist_r <= {sample_hist_r[1:0], line_sync_r};
			line_prev_r <= line_sync_r;
		end
	end

	always @* begin
		rx_state_nxt = rx_state_r;
		case (rx_state_r)
			ST_IDLE: begin
				// Overrun holds the receiver off entirely
				if (start_edge && !overrun_error_r)
					rx_state_nxt = ST_START;
			end
			ST_START: begin
				if (centre_tick)
					rx_state_nxt = majority ? ST_IDLE : ST_DATA;
			end
			ST_DATA: begin
				if (centre_tick && rx_bits_r == 4'h1)
					rx_state_nxt = ST_STOP;
			end
			ST_STOP: begin
				if (centre_tick)
					rx_state_nxt = ST_IDLE;
			end
			default: begin
				rx_state_nxt = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_in) begin
		if (!rstn_in || !rx_active) begin
			rx_state_r <= ST_IDLE;
			rx_tick_cnt_r <= 4'h0;
			rx_bits_r <= 4'h0;
			receive_shifter_r <= 9'h000;
			rx_nine_r <= 1'b0;
		end else begin
			rx_state_r <= rx_state_nxt;
			if (rx_state_r == ST_IDLE) begin
				rx_tick_cnt_r <= 4'h0;
				// Width is fixed per character at its start
				rx_nine_r <= nine_bit_receive_select;
				rx_bits_r <= nine_bit_receive_select ? 4'h9 : 4'h8;
			end else if (baud_tick_in) begin
				if (centre_tick)
					rx_tick_cnt_r <= 4'h0;
				else
					rx_tick_cnt_r <= rx_tick_cnt_r + 4'h1;
			end
			if (data_sample) begin
				// LSB arrives first, so shift in from the top
				receive_shifter_r <= {majority,
					receive_shifter_r[8:1]};
				rx_bits_r <= rx_bits_r - 4'h1;
			end
		end
	end

	// Push one cycle after the stop sample, with its own framing bit
	always @(posedge clk_in) begin
		if (!rstn_in || !rx_active) begin
			push_r <= 1'b0;
			push_data_r <= 10'h000;
		end else begin
			push_r <= stop_sample;
			if (stop_sample) begin
				push_data_r[9] <= ~majority;
				push_data_r[8:0] <= rx_nine_r ? receive_shifter_r :
					{1'b0, receive_shifter_r[8:1]};
			end
		end
	end

	// Overrun: stays until receive or port enable is cleared or clocked mode is set
	always @(posedge clk_in) begin
		if (!rstn_in || !rx_active) begin
			overrun_error_r <= 1'b0;
		end else if (push_r && !fifo_ready) begin
			overrun_error_r <= 1'b1;
		end
	end

	// Buffered data and framing errors survive a receive-enable clear; overrun does not
	assign fifo_flush = !port_enable;
	assign fifo_pop = rd_in && addr_in == `REG_RX_DATA;

	serial_rx_fifo #(
		.WIDTH(10),
		.DEPTH(`RX_FIFO_DEPTH)
	) u_rx_fifo (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.flush_in(fifo_flush),
		.push_valid_in(push_r && !overrun_error_r),
		.push_ready_out(fifo_ready),
		.push_data_in(push_data_r),
		.pop_valid_out(fifo_valid),
		.pop_ready_in(fifo_pop),
		.pop_data_out(fifo_head)
	);

	// Not gated by any interrupt enable; none exist in this block
	assign receive_interrupt_flag_out = rx_active &&
		fifo_valid;

	// Register read port

	// Drained buffer shows no stale status of a popped entry
	assign head_framing_error = fifo_head[9] & fifo_valid;
	assign head_ninth_bit = fifo_head[8] & fifo_valid;

	assign status_word = {
		2'b00,
		tx_shifter_empty,
		head_ninth_bit,
		overrun_error_r,
		head_framing_error,
		receive_interrupt_flag_out,
		transmit_interrupt_flag_out
	};

	always @(posedge clk_in) begin
		if (!rstn_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			case (addr_in)
				`REG_CONTROL: begin
					rdata_out <= control_r;
				end
				`REG_STATUS: begin
					rdata_out <= status_word;
				end
				`REG_RX_DATA: begin
					rdata_out <= fifo_head[7:0];
				end
				`REG_TX_DATA: begin
					// Transmit data is write-only
					rdata_out <= 8'h00;
				end
				default: begin
					rdata_out <= 8'h00;
				end
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end
endmodule
`default_nettype wire

//--- verification/serial_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.vh"
module serial_port_asserts (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic baud_tick_in,
	input wire logic [2:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic receive_line_in,
	input wire logic transmit_line_out,
	input wire logic receive_interrupt_flag_out,
	input wire logic transmit_interrupt_flag_out
);
	logic [7:0] ctl_r;
	// Shadow of control, so gating is judged from the bus alone
	always @(posedge clk_in) begin
		if (!rstn_in) begin
			ctl_r <= `CONTROL_RESET;
		end else if (wr_in && addr_in == `REG_CONTROL) begin
			ctl_r <= wdata_in;
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	rdata_idle_a: assert property (
		!$past(rd_in) |-> rdata_out == 8'h00) else $error("stray read data");
	status_flags_a: assert property (
		rd_in && addr_in == `REG_STATUS |=>
		rdata_out[`STA_RX_FLAG] == $past(receive_interrupt_flag_out) &&
		rdata_out[`STA_TX_FLAG] == $past(transmit_interrupt_flag_out))
		else $error("status flags differ from flag pins");
	unmapped_read_a: assert property (
		rd_in && addr_in > 3'h3 |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	rx_gate_a: assert property (
		!(ctl_r[`CTL_PORT_ENABLE] && ctl_r[`CTL_RECEIVE_ENABLE] &&
		!ctl_r[`CTL_CLOCKED_MODE]) |-> !receive_interrupt_flag_out)
		else $error("receive flag while receiver off");
	tx_gate_a: assert property (
		!(ctl_r[`CTL_PORT_ENABLE] && ctl_r[`CTL_TRANSMITTER_ENABLE]) |->
		!transmit_interrupt_flag_out) else $error("transmit flag while off");
	tx_enable_flag_a: assert property (
		$rose(ctl_r[`CTL_PORT_ENABLE]) && ctl_r[`CTL_TRANSMITTER_ENABLE] &&
		!ctl_r[`CTL_CLOCKED_MODE] |-> transmit_interrupt_flag_out)
		else $error("transmit flag not set on enable");
	tx_flag_fall_a: assert property (
		$fell(transmit_interrupt_flag_out) |-> $past(wr_in &&
		(addr_in == `REG_TX_DATA || addr_in == `REG_CONTROL)))
		else $error("transmit flag fell without a write");
	rx_flag_fall_a: assert property (
		$fell(receive_interrupt_flag_out) |->
		$past(rd_in && addr_in == `REG_RX_DATA) ||
		$past(rd_in && addr_in == `REG_RX_DATA, 2) ||
		$past(wr_in && addr_in == `REG_CONTROL))
		else $error("receive flag fell without a pop");
	line_idle_a: assert property (
		!ctl_r[`CTL_PORT_ENABLE] && !ctl_r[`CTL_POLARITY_INVERT] &&
		$past(!ctl_r[`CTL_PORT_ENABLE]) |-> transmit_line_out)
		else $error("idle line not high");
endmodule
bind serial_port serial_port_asserts chk (.clk_in(clk_in),
	.rstn_in(rstn_in), .baud_tick_in(baud_tick_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .receive_line_in(receive_line_in),
	.transmit_line_out(transmit_line_out),
	.receive_interrupt_flag_out(receive_interrupt_flag_out),
	.transmit_interrupt_flag_out(transmit_interrupt_flag_out));
`default_nettype wire

//--- verification/serial_line_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_line_peer (
	input wire logic clk_in,
	input wire logic tick_in,
	input wire logic line_in,
	output logic line_out
);
	initial line_out = 1'b1;
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk_in);
			while (!tick_in) @(posedge clk_in);
		end
	endtask
	// Bits last exactly sixteen ticks; no skew margin is tested
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		line_out <= 1'b0;
		ticks(16);
		for (int i = 0; i < n; i++) begin
			line_out <= d[i];
			ticks(16);
		end
		line_out <= stop;
		ticks(16);
		line_out <= 1'b1;
		ticks(16);
	endtask
	task automatic glitch;
		line_out <= 1'b0;
		ticks(4);
		line_out <= 1'b1;
		ticks(32);
	endtask
	task automatic recv(input int n, output logic [8:0] d, output logic s);
		int w;
		w = 0;
		d = 9'h000;
		while (line_in !== 1'b0 && w < 5000) begin
			@(posedge clk_in);
			w++;
		end
		ticks(8);
		for (int i = 0; i < n; i++) begin
			ticks(16);
			d[i] = line_in;
		end
		ticks(16);
		s = line_in;
	endtask
endmodule
`default_nettype wire

//--- verification/test_async_serial_tx9_and_receiver.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
err_count++; $display("unexpected %0t got %h exp %h", $time, a, b); end end
module test_async_serial_tx9_and_receiver;
	logic clk_in, rstn_in, baud_tick_in, wr_in, rd_in, rx_line, tx_line;
	logic rx_flag, tx_flag, sb;
	logic [2:0] addr_in;
	logic [7:0] wdata_in, rdata_out, v;
	logic [8:0] d9;
	logic [1:0] tdiv;
	int err_count, samples_checked, cycles;
	serial_port DUT (.clk_in(clk_in), .rstn_in(rstn_in),
		.baud_tick_in(baud_tick_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.receive_line_in(rx_line), .transmit_line_out(tx_line),
		.receive_interrupt_flag_out(rx_flag),
		.transmit_interrupt_flag_out(tx_flag));
	serial_line_peer peer (.clk_in(clk_in), .tick_in(baud_tick_in),
		.line_in(tx_line), .line_out(rx_line));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// Fast tick keeps frames short: one tick every four clocks
	always @(posedge clk_in) begin
		tdiv <= tdiv + 2'h1;
		baud_tick_in <= (tdiv == 2'h3);
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_count++;
			close_out;
		end
	end
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task rd(input logic [2:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask
	task t_regs;
		rd(`REG_CONTROL);
		`CHK(v, `CONTROL_RESET)
		wr(3'h6, 8'hFF);
		rd(3'h6);
		`CHK(v, 8'h00)
		wr(`REG_CONTROL, 8'h07);
		#1 `CHK(tx_flag, 1'b1)
	endtask
	task t_tx;
		wr(`REG_TX_DATA, 8'hA5);
		wr(`REG_TX_DATA, 8'h5A);
		#1 `CHK(tx_flag, 1'b0)
		rd(`REG_STATUS);
		`CHK(v[`STA_SHIFTER_EMPTY], 1'b0)
		peer.recv(8, d9, sb);
		`CHK(d9[7:0], 8'hA5)
		`CHK(sb, 1'b1)
		peer.recv(8, d9, sb);
		`CHK(d9[7:0], 8'h5A)
		peer.ticks(16);
		wr(`REG_CONTROL, 8'h8F);
		wr(`REG_TX_DATA, 8'h3C);
		peer.recv(9, d9, sb);
		`CHK(d9, 9'h13C)
		peer.ticks(16);
		wr(`REG_CONTROL, 8'h07);
	endtask
	task t_rx;
		peer.send(9'h096, 8, 1'b1);
		peer.send(9'h041, 8, 1'b0);
		`CHK(rx_flag, 1'b1)
		rd(`REG_STATUS);
		`CHK(v[`STA_FRAMING_ERROR], 1'b0)
		rd(`REG_RX_DATA);
		`CHK(v, 8'h96)
		rd(`REG_STATUS);
		`CHK(v[`STA_FRAMING_ERROR], 1'b1)
		rd(`REG_RX_DATA);
		`CHK(v, 8'h41)
		@(posedge clk_in);
		#1 `CHK(rx_flag, 1'b0)
		peer.glitch;
		// Long enough for a wrongly kept start to finish a character
		peer.ticks(160);
		`CHK(rx_flag, 1'b0)
		peer.send(9'h03C, 8, 1'b1);
		rd(`REG_RX_DATA);
		`CHK(v, 8'h3C)
		wr(`REG_CONTROL, 8'h17);
		peer.send(9'h1A5, 9, 1'b1);
		rd(`REG_STATUS);
		`CHK(v[`STA_RX_NINTH_BIT], 1'b1)
		rd(`REG_RX_DATA);
		`CHK(v, 8'hA5)
		wr(`REG_CONTROL, 8'h07);
	endtask
	task t_overrun;
		peer.send(9'h011, 8, 1'b1);
		peer.send(9'h022, 8, 1'b1);
		peer.send(9'h033, 8, 1'b1);
		rd(`REG_STATUS);
		`CHK(v[`STA_OVERRUN_ERROR], 1'b1)
		rd(`REG_RX_DATA);
		`CHK(v, 8'h11)
		rd(`REG_RX_DATA);
		`CHK(v, 8'h22)
		@(posedge clk_in);
		#1 `CHK(rx_flag, 1'b0)
		// Dropping receive enable clears overrun here; clearing port enable or setting clocked mode would too
		wr(`REG_CONTROL, 8'h05);
		wr(`REG_CONTROL, 8'h07);
		peer.send(9'h044, 8, 1'b1);
		rd(`REG_RX_DATA);
		`CHK(v, 8'h44)
	endtask
	task t_gate;
		peer.send(9'h077, 8, 1'b1);
		wr(`REG_CONTROL, 8'h05);
		#1 `CHK(rx_flag, 1'b0)
		wr(`REG_CONTROL, 8'h07);
		#1 `CHK(rx_flag, 1'b1)
		wr(`REG_CONTROL, 8'h00);
		wr(`REG_CONTROL, 8'h07);
		#1 `CHK(rx_flag, 1'b0)
		wr(`REG_CONTROL, 8'h23);
		peer.send(9'h066, 8, 1'b1);
		wr(`REG_CONTROL, 8'h07);
		#1 `CHK(rx_flag, 1'b0)
	endtask
	task close_out;
		$display("checked %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		err_count = 0;
		samples_checked = 0;
		cycles = 0;
		tdiv = 2'h0;
		rstn_in = 1'b0;
		baud_tick_in = 1'b0;
		addr_in = 3'h0;
		wdata_in = 8'h00;
		wr_in = 1'b0;
		rd_in = 1'b0;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		t_regs;
		t_tx;
		t_rx;
		t_overrun;
		t_gate;
		close_out;
	end
endmodule
`default_nettype wire
